// *** design/tx_buffer_command_unpacker.sv ***
// Transmit buffer command unpacker with Avalon-MM register port
`timescale 1ns/1ps
`include "txcmd_defs.svh"

// How it works
// R1: Command A bits 20:16 give start offset
// R2: Command A bit 13 opens a packet
// R3: Command A bit 12 closes a packet
// R4: Sum buffer sizes; mismatch sets error
// R5: Packet length counts payload bytes only
// R6: Length mismatch sets transmit error flag
// R7: Tag copied unchanged to status
// R8: Any tag value accepted, no meaning
// R9: Checksum needs request, first segment, engine
// R10: Command B bit 13 omits CRC
// R11: Command B bit 12 stops short padding
// R12: No padding forces CRC anyway
// R13: Host writes reserved bits as zero
// R14: Payload starts at third word
// R15: Offset low bits pick first lane
// R16: Offset upper bits skip whole words
// R17: Trailing unused bytes never forwarded
// R18: Host fills buffer to alignment
// R19: Alignment filler words are stripped
// R20: Alignment code 00/01/10 is 4/16/32
// R21: Completion bit set after buffer loaded
// R22: Byte stream with lane valids, boundaries
module tx_buffer_command_unpacker #(
	parameter int CNT_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [31:0] txData,
	output logic [3:0] txByteEn,
	output logic txValid,
	input wire logic txReady,
	output logic txSop,
	output logic txEop,
	output logic [15:0] txTag,
	output logic txCsumEn,
	output logic txAddCrc,
	output logic txPadEn
);
	import txcmd_pkg::*;

	generate
		if (CNT_W < 12 || CNT_W > 16) begin : gBadWidth
			$error("CNT_W must lie between 12 and 16");
		end
	endgenerate

	unp_s s_reg;
	unp_s s_next;
	logic dataHit;
	logic dataAccept;
	logic errSet;
	logic doneSet;
	logic bufDone;
	logic inData;
	logic [1:0] laneLo;
	logic [1:0] laneHi;
	logic [3:0] laneMask;
	logic [11:0] offPlusSize;
	logic [11:0] laneBytes;
	logic [15:0] newCount;
	logic [10:0] checkLen;

	// Words needed for a byte count at the given alignment
	function automatic logic [11:0] wordsUp(input logic [11:0] bytes,
		input logic [1:0] al);
		logic [11:0] m;
		m = `TXC_MASK_4;
		// R20: alignment decode
		if (al == `TXC_ALIGN_16) begin
			m = `TXC_MASK_16;
		end else if (al == `TXC_ALIGN_32) begin
			m = `TXC_MASK_32;
		end
		return ((bytes + m) & ~m) >> 2;
	endfunction

	byte_lane_mask uLanes (
		.lo(laneLo),
		.hi(laneHi),
		.mask(laneMask)
	);

	// Stall data writes while the output word is held with txReady low, and a read's first cycle; register writes never wait
	assign dataHit = write && (address == `TXC_OFF_DATA);
	assign dataAccept = dataHit && !(s_reg.outValid && !txReady);
	assign waitrequest = (read && !s_reg.rdPend)
		|| (dataHit && s_reg.outValid && !txReady);

	assign offPlusSize = {7'h00, writedata[`TXC_A_OFF_MSB:`TXC_A_OFF_LSB]}
		+ {1'b0, writedata[`TXC_LEN_MSB:0]};
	assign laneBytes = {10'h000, writedata[`TXC_A_OFF_LSB+1:`TXC_A_OFF_LSB]}
		+ {1'b0, writedata[`TXC_LEN_MSB:0]};
	assign newCount = (writedata[`TXC_A_FS_BIT] ? 16'h0000 : s_reg.runCount)
		+ {5'h00, writedata[`TXC_LEN_MSB:0]};
	assign checkLen = s_reg.fs ? writedata[`TXC_LEN_MSB:0] : s_reg.pktLen;
	assign inData = (s_reg.idx >= s_reg.skipW) && (s_reg.idx < s_reg.dataEnd);
	// R15: first word starts at the offset lane
	assign laneLo = (s_reg.idx == s_reg.skipW) ? s_reg.startOff[1:0] : 2'h0;
	// R17: last word ends at the final payload byte
	assign laneHi = (s_reg.idx == 12'(s_reg.dataEnd - 12'h001))
		? 2'(s_reg.startOff[1:0] + s_reg.bufSize[1:0] - 2'h1) : 2'h3;

	always_comb begin
		s_next = s_reg;
		errSet = 1'b0;
		doneSet = 1'b0;
		bufDone = 1'b0;
		if (s_reg.outValid && txReady) begin
			s_next.outValid = 1'b0;
		end
		if (write && address == `TXC_OFF_CTRL && byteenable[0]) begin
			s_next.csumEngEn = writedata[`TXC_CTRL_CSUM_BIT];
		end
		if (write && address == `TXC_OFF_STATUS && byteenable[0]) begin
			if (writedata[`TXC_STAT_ERR_BIT]) begin
				s_next.txErr = 1'b0;
			end
			if (writedata[`TXC_STAT_DONE_BIT]) begin
				s_next.txDone = 1'b0;
			end
		end
		// Reads answer one cycle late so readdata comes from a flop
		s_next.rdPend = read && !s_reg.rdPend;
		if (read && !s_reg.rdPend) begin
			case (address)
				`TXC_OFF_CTRL: s_next.rdData = {31'h0, s_reg.csumEngEn};
				`TXC_OFF_STATUS: s_next.rdData = {s_reg.lastTag, 14'h0,
					s_reg.txDone, s_reg.txErr};
				default: s_next.rdData = 32'h0000_0000;
			endcase
		end
		if (dataAccept) begin
			case (s_reg.st)
				ST_CMDA: begin
					// R1: start offset field
					s_next.startOff = writedata[`TXC_A_OFF_MSB:`TXC_A_OFF_LSB];
					// R2: opening segment
					s_next.fs = writedata[`TXC_A_FS_BIT];
					// R3: closing segment
					s_next.ls = writedata[`TXC_A_LS_BIT];
					s_next.completion_request_bit = writedata[`TXC_A_IOC_BIT];
					s_next.align =
						writedata[`TXC_A_ALIGN_MSB:`TXC_A_ALIGN_LSB];
					s_next.bufSize = writedata[`TXC_LEN_MSB:0];
					// R4: running total of buffer sizes
					s_next.runCount = newCount;
					// R16: whole words skipped before data
					s_next.skipW =
						{9'h000, writedata[`TXC_A_OFF_MSB:`TXC_A_SKIP_LSB]};
					s_next.dataEnd = 12'(
						{9'h000, writedata[`TXC_A_OFF_MSB:`TXC_A_SKIP_LSB]}
						+ wordsUp(laneBytes, 2'h0));
					// R18: host padded up to this word count
					s_next.totalW = wordsUp(offPlusSize,
						writedata[`TXC_A_ALIGN_MSB:`TXC_A_ALIGN_LSB]);
					if (writedata[`TXC_A_FS_BIT]) begin
						s_next.sopPend = 1'b1;
					end
					s_next.st = ST_CMDB;
				end
				ST_CMDB: begin
					// R13: reserved bits are simply not decoded
					if (s_reg.fs) begin
						// R5: payload length of whole packet
						s_next.pktLen = writedata[`TXC_LEN_MSB:0];
						// R8: tag passes through, never checked
						s_next.fTag =
							writedata[`TXC_B_TAG_MSB:`TXC_B_TAG_LSB];
						// R9: all three conditions together
						s_next.fCsum = writedata[`TXC_B_CK_BIT]
							&& s_reg.csumEngEn;
						// R10: CRC omit, R12 overrides it
						s_next.fAddCrc = !writedata[`TXC_B_NOCRC_BIT]
							|| writedata[`TXC_B_NOPAD_BIT];
						// R11: padding suppression
						s_next.fPad = !writedata[`TXC_B_NOPAD_BIT];
					end
					// R6: packet length against bytes supplied
					if (s_reg.ls && s_reg.runCount != {5'h00, checkLen}) begin
						errSet = 1'b1;
					end
					s_next.idx = 12'h000;
					// R14: body follows the two command words
					if (s_reg.totalW == 12'h000) begin
						bufDone = 1'b1;
						s_next.st = ST_CMDA;
					end else begin
						s_next.st = ST_BODY;
					end
				end
				ST_BODY: begin
					// R19: filler and skipped words load nothing
					if (inData) begin
						// R22: lane valids and packet boundaries
						s_next.outData = writedata;
						s_next.outBe = laneMask;
						s_next.outValid = 1'b1;
						s_next.outSop = s_reg.sopPend;
						s_next.outEop = s_reg.ls && (s_reg.idx
							== 12'(s_reg.dataEnd - 12'h001));
						s_next.sopPend = 1'b0;
					end
					s_next.idx = 12'(s_reg.idx + 12'h001);
					if (12'(s_reg.idx + 12'h001) == s_reg.totalW) begin
						bufDone = 1'b1;
						s_next.st = ST_CMDA;
					end
				end
				default: s_next.st = ST_CMDA;
			endcase
		end
		// R21: completion after the whole buffer is taken
		doneSet = bufDone && s_reg.completion_request_bit;
		// Hardware sets win over a same-cycle software clear
		if (errSet) begin
			s_next.txErr = 1'b1;
		end
		if (doneSet) begin
			s_next.txDone = 1'b1;
		end
		// R7: tag of the finished packet shown in status
		if (bufDone && s_reg.ls) begin
			s_next.lastTag = s_reg.fTag;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
			s_reg.st <= ST_CMDA;
			s_reg.csumEngEn <= `TXC_RST_CSUM_EN;
			s_reg.fAddCrc <= 1'b1;
			s_reg.fPad <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign readdata = s_reg.rdData;
	assign txData = s_reg.outData;
	assign txByteEn = s_reg.outBe;
	assign txValid = s_reg.outValid;
	assign txSop = s_reg.outSop;
	assign txEop = s_reg.outEop;
	assign txTag = s_reg.fTag;
	assign txCsumEn = s_reg.fCsum;
	assign txAddCrc = s_reg.fAddCrc;
	assign txPadEn = s_reg.fPad;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	property p_csum;
		(dataAccept && s_reg.st == ST_CMDB && s_reg.fs) |=>
			txCsumEn == ($past(writedata[14]) && $past(s_reg.csumEngEn));
	endproperty
	a_csum: assert property (p_csum) else $error("checksum enable wrong"); // R9

	property p_padCrc;
		!txPadEn |-> txAddCrc;
	endproperty
	a_padCrc: assert property (p_padCrc) else $error("CRC dropped"); // R12

	property p_noCrc;
		(dataAccept && s_reg.st == ST_CMDB && s_reg.fs
			&& writedata[13] && !writedata[12]) |=> !txAddCrc;
	endproperty
	a_noCrc: assert property (p_noCrc) else $error("CRC not omitted"); // R10

	property p_tag;
		(dataAccept && s_reg.st == ST_CMDB && s_reg.fs)
			|=> txTag == $past(writedata[31:16]);
	endproperty
	a_tag: assert property (p_tag) else $error("tag altered"); // R7

	property p_lenErr;
		(dataAccept && s_reg.st == ST_CMDB && s_reg.ls
			&& s_reg.runCount != {5'h00, checkLen})
			|=> s_reg.txErr;
	endproperty
	a_lenErr: assert property (p_lenErr) else $error("no length error"); // R6

	property p_skip;
		(dataAccept && s_reg.st == ST_BODY && s_reg.idx < s_reg.skipW)
			|=> !txValid;
	endproperty
	a_skip: assert property (p_skip) else $error("skipped word sent"); // R16

	property p_lane3;
		(dataAccept && s_reg.st == ST_BODY && s_reg.idx == s_reg.skipW
			&& inData && s_reg.startOff[1:0] == 2'h3)
			|=> txByteEn[2:0] == 3'h0 && txByteEn[3] && txValid;
	endproperty
	a_lane3: assert property (p_lane3) else $error("first lane wrong"); // R15

	property p_fill;
		(dataAccept && s_reg.st == ST_BODY && s_reg.idx >= s_reg.dataEnd)
			|=> !txValid ##1 (s_reg.st == ST_CMDA || !txValid);
	endproperty
	a_fill: assert property (p_fill) else $error("filler forwarded"); // R19

	property p_done;
		(dataAccept && s_reg.st == ST_BODY && s_reg.completion_request_bit
			&& 12'(s_reg.idx + 12'h001) == s_reg.totalW)
			|=> s_reg.txDone && s_reg.st == ST_CMDA;
	endproperty
	a_done: assert property (p_done) else $error("completion missed"); // R21
endmodule

// *** design/txcmd_defs.svh ***
// Offsets, field positions and reset values of the transmit command unpacker
`ifndef TXCMD_DEFS_SVH
`define TXCMD_DEFS_SVH

`define TXC_OFF_DATA 4'h0
`define TXC_OFF_CTRL 4'h4
`define TXC_OFF_STATUS 4'h8

`define TXC_CTRL_CSUM_BIT 0
`define TXC_STAT_ERR_BIT 0
`define TXC_STAT_DONE_BIT 1
`define TXC_STAT_TAG_LSB 16

`define TXC_A_IOC_BIT 31
`define TXC_A_ALIGN_MSB 25
`define TXC_A_ALIGN_LSB 24
`define TXC_A_OFF_MSB 20
`define TXC_A_OFF_LSB 16
`define TXC_A_SKIP_LSB 18
`define TXC_A_FS_BIT 13
`define TXC_A_LS_BIT 12
`define TXC_LEN_MSB 10

`define TXC_B_TAG_MSB 31
`define TXC_B_TAG_LSB 16
`define TXC_B_CK_BIT 14
`define TXC_B_NOCRC_BIT 13
`define TXC_B_NOPAD_BIT 12

`define TXC_ALIGN_16 2'h1
`define TXC_ALIGN_32 2'h2
`define TXC_MASK_4 12'h003
`define TXC_MASK_16 12'h00F
`define TXC_MASK_32 12'h01F

`define TXC_RST_CSUM_EN 1'h0

`endif

// *** design/txcmd_pkg.sv ***
// Types shared by the transmit command unpacker
package txcmd_pkg;

	typedef enum logic [2:0] {
		ST_CMDA = 3'b001,
		ST_CMDB = 3'b010,
		ST_BODY = 3'b100
	} unp_state_e;

	typedef struct packed {
		unp_state_e st;
		logic [4:0] startOff;
		logic [1:0] align;
		logic fs;
		logic ls;
		logic completion_request_bit;
		logic [10:0] bufSize;
		logic [11:0] idx;
		logic [11:0] skipW;
		logic [11:0] dataEnd;
		logic [11:0] totalW;
		logic [15:0] runCount;
		logic [10:0] pktLen;
		logic sopPend;
		logic csumEngEn;
		logic txErr;
		logic txDone;
		logic [15:0] lastTag;
		logic [15:0] fTag;
		logic fCsum;
		logic fAddCrc;
		logic fPad;
		logic [31:0] outData;
		logic [3:0] outBe;
		logic outValid;
		logic outSop;
		logic outEop;
		logic [31:0] rdData;
		logic rdPend;
	} unp_s;

endpackage

// *** design/byte_lane_mask.sv ***
// Byte lane qualifier for one data word, lanes lo through hi valid
`timescale 1ns/1ps
module byte_lane_mask (
	input wire logic [1:0] lo,
	input wire logic [1:0] hi,
	output logic [3:0] mask
);
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gLane
			assign mask[g] = (2'(g) >= lo) && (2'(g) <= hi);
		end
	endgenerate
endmodule

// *** verification/host_bus_model.sv ***
// Host model writing transmit buffers over the register bus
`timescale 1ns/1ps
module host_bus_model (
	input wire logic sys_clk,
	input wire logic waitrequest,
	input wire logic [31:0] readdata,
	output logic [3:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable
);
	int waits = 0;

	initial begin
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h0;
	end

	// Held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic [3:0] a, input logic rd,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		address <= a;
		read <= rd;
		write <= !rd;
		writedata <= d;
		byteenable <= 4'hF;
		waits = 0;
		@(posedge sys_clk);
		while (waitrequest) begin
			waits++;
			@(posedge sys_clk);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		writedata <= ~d;
	endtask

	task automatic send(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] base);
		int al;
		int n;
		logic [31:0] q;
		a = a & 32'h831F_37FF;
		b = b & 32'hFFFF_77FF;
		al = (a[25:24] == 2'h1) ? 16 : (a[25:24] == 2'h2) ? 32 : 4;
		n = (int'(a[20:16]) + int'(a[10:0]) + al - 1) / al * al / 4;
		xfer(4'h0, 1'b0, a, q);
		xfer(4'h0, 1'b0, b, q);
		for (int i = 0; i < n; i++)
			xfer(4'h0, 1'b0, base ^ 32'(i), q);
	endtask
endmodule

// *** verification/tb_top.sv ***
// Testbench for the transmit command unpacker
`timescale 1ns/1ps
module tb_top;
	import txcmd_pkg::*;
	logic sysClk, rstB, rd, wr, waitReq, txReady;
	logic txValid, txSop, txEop, txCsumEn, txAddCrc, txPadEn;
	logic [3:0] addr, be, txByteEn;
	logic [31:0] wd, rdData, txData, q;
	logic [15:0] txTag;
	logic [37:0] rxQ[$];
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;

	tx_buffer_command_unpacker DUT (.sys_clk(sysClk), .rst_b(rstB),
		.address(addr), .read(rd), .write(wr), .writedata(wd),
		.byteenable(be), .readdata(rdData), .waitrequest(waitReq),
		.txData(txData), .txByteEn(txByteEn), .txValid(txValid),
		.txReady(txReady), .txSop(txSop), .txEop(txEop), .txTag(txTag),
		.txCsumEn(txCsumEn), .txAddCrc(txAddCrc), .txPadEn(txPadEn));
	host_bus_model host (.sys_clk(sysClk), .waitrequest(waitReq),
		.readdata(rdData), .address(addr), .read(rd), .write(wr),
		.writedata(wd), .byteenable(be));

	initial begin
		sysClk = 1'b0;
		forever #25 sysClk = ~sysClk;
	end

	always @(posedge sysClk) begin
		if (txValid && txReady)
			rxQ.push_back({txSop, txEop, txByteEn, txData});
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge sysClk);
		#1;
	endtask

	task automatic expWord(input logic [37:0] e);
		logic [37:0] g;
		g = 'x;
		if (rxQ.size() > 0)
			g = rxQ.pop_front();
		chk("word", {26'h0, e}, {26'h0, g});
	endtask

	task automatic sBasic();
		host.send(32'h0000_3004, 32'h1234_0004, 32'hA1B2_C3D4);
		settle();
		expWord({2'b11, 4'hF, 32'hA1B2_C3D4});
		chk("tag", 64'h1234, 64'(txTag));
		chk("crc", 64'h1, 64'(txAddCrc));
		chk("pad", 64'h1, 64'(txPadEn));
	endtask

	task automatic sOffset();
		host.send(32'h0106_3003, 32'h0BEE_7003, 32'h5566_7788);
		settle();
		expWord({2'b10, 4'hC, 32'h5566_7789});
		expWord({2'b01, 4'h1, 32'h5566_778A});
		chk("extra", 64'h0, 64'(rxQ.size()));
		chk("csum", 64'h0, 64'(txCsumEn));
		chk("crc", 64'h1, 64'(txAddCrc));
		chk("pad", 64'h0, 64'(txPadEn));
		host.xfer(4'h8, 1'b1, 32'h0, q);
		chk("status", 64'h0, 64'(q[1:0]));
	endtask

	task automatic sError();
		host.send(32'h0000_2004, 32'h00A5_0008, 32'h1111_2222);
		host.send(32'h8000_1003, 32'h7777_0003, 32'h3333_4444);
		settle();
		expWord({2'b10, 4'hF, 32'h1111_2222});
		expWord({2'b01, 4'h7, 32'h3333_4444});
		chk("tag", 64'h00A5, 64'(txTag));
		host.xfer(4'h8, 1'b1, 32'h0, q);
		chk("status", 64'h00A5_0003, 64'(q));
		host.xfer(4'h8, 1'b0, 32'h3, q);
		host.xfer(4'h8, 1'b1, 32'h0, q);
		chk("cleared", 64'h00A5_0000, 64'(q));
	endtask

	task automatic sCsum();
		host.xfer(4'h4, 1'b0, 32'h1, q);
		host.xfer(4'h4, 1'b1, 32'h0, q);
		chk("ctrl", 64'h1, 64'(q));
		host.send(32'h0000_3004, 32'hFFFF_6004, 32'h0F0F_0F0F);
		settle();
		expWord({2'b11, 4'hF, 32'h0F0F_0F0F});
		chk("csum", 64'h1, 64'(txCsumEn));
		chk("crc", 64'h0, 64'(txAddCrc));
		chk("tag", 64'hFFFF, 64'(txTag));
		host.xfer(4'hC, 1'b1, 32'h0, q);
		chk("unmapped", 64'h0, 64'(q));
	endtask

	// Consumer stalls; second data word must wait three edges
	task automatic sStall();
		@(posedge sysClk);
		txReady <= 1'b0;
		fork
			host.send(32'h0300_3008, 32'h0042_0008, 32'hC0DE_0000);
			begin
				repeat (10) @(posedge sysClk);
				txReady <= 1'b1;
			end
		join
		chk("stallWait", 64'h3, 64'(host.waits));
		settle();
		expWord({2'b10, 4'hF, 32'hC0DE_0000});
		expWord({2'b01, 4'hF, 32'hC0DE_0001});
		chk("idle", 64'h0, 64'(txValid));
	endtask

	task automatic sLane3();
		host.send(32'h0203_3002, 32'h0007_0002, 32'h9988_7766);
		settle();
		expWord({2'b10, 4'h8, 32'h9988_7766});
		expWord({2'b01, 4'h1, 32'h9988_7767});
		chk("tail", 64'h0, 64'(rxQ.size()));
		host.xfer(4'h8, 1'b1, 32'h0, q);
		chk("rdWait", 64'h1, 64'(host.waits));
		chk("status3", 64'h0007_0000, 64'(q));
	endtask

	initial begin
		rstB = 1'b0;
		txReady = 1'b1;
		repeat (4) @(posedge sysClk);
		rstB <= 1'b1;
		#1;
		chk("rstCrc", 64'h1, 64'(txAddCrc));
		sBasic();
		sOffset();
		sError();
		sCsum();
		sStall();
		sLane3();
		complete_run();
	end
endmodule
